// ===== src/count_value_pkg.sv
/*
 * Package for the external-reset mode timer: register map, mode encodings,
 * reset values and widths. Assumes a 32-bit AXI4-Lite register bus.
 */
package count_value_pkg;
    // ==========================================================
    // Register offsets (byte addresses)
    localparam logic [7:0] COUNT_VALUE_CTRL_OFS = 8'h00;
    localparam logic [7:0] COUNT_VALUE_MODE_OFS = 8'h04;
    localparam logic [7:0] COUNT_VALUE_SRC_OFS = 8'h08;
    localparam logic [7:0] COUNT_VALUE_PERIOD_OFS = 8'h0C;
    localparam logic [7:0] COUNT_VALUE_COUNT_OFS = 8'h10;
    localparam logic [7:0] COUNT_VALUE_STAT_OFS = 8'h14;
    // ==========================================================
    // Field positions and reset values
    localparam int COUNT_VALUE_CTRL_EN_BIT = 0;
    localparam int COUNT_VALUE_CTRL_FRZ_BIT = 1;
    localparam logic [7:0] COUNT_VALUE_PERIOD_RST = 8'hFF;
    localparam logic [4:0] COUNT_VALUE_MODE_RST = 5'h00;
    localparam logic [2:0] COUNT_VALUE_SRC_RST = 3'h0;
    localparam int COUNT_VALUE_SRC_W = 3;
    localparam int COUNT_VALUE_NSRC = 8;
    // ==========================================================
    // Mode families (upper two bits of the mode field)
    localparam logic [1:0] COUNT_VALUE_FAM_FREE = 2'h0;
    localparam logic [1:0] COUNT_VALUE_FAM_ONESHOT = 2'h1;
    localparam logic [1:0] COUNT_VALUE_FAM_MONO = 2'h2;
    // AXI responses
    localparam logic [1:0] COUNT_VALUE_RESP_OKAY = 2'h0;
    localparam logic [1:0] COUNT_VALUE_RESP_SLVERR = 2'h2;
endpackage

// ===== src/count_value_timer.sv
/*
 * External-reset mode timer: 8-bit count against a period value, steered by a
 * five-bit mode field and one selected external reset signal.
 * Assumes a synchronous prescaled clock aclk and a single AXI4-Lite master.
 */
`timescale 1ns/1ns
// Notes on behaviour
// - One external reset input, picked from several sources by a software select register.
// - Five-bit mode: upper two bits choose family, lower three choose variant.
// - External input is ignored entirely while debug freeze is active.
// - Free codes 000/001/010: count with enable, plus input high or low.
// - Free code 011: any edge clears count, enabled or not; stop when disabled.
// - Free codes 100/101: rising or falling edge clears; counts while enabled.
// - Free codes 110/111: held clear while input low or high respectively.
// - One-shot 000 starts when software sets enable.
// - One-shot 001/010/011 start on enable plus rising, falling or any edge.
// - One-shot 100/101: qualifying edge both starts and clears the count.
// - One-shot 110/111: start on edge, clear while input at the opposite level.
// - One-shot: clock after count equals period clears enable, count stops at zero.
// - Edge-started modes need a fresh edge after enable is set again.
// - Monostable 001-011: stop at zero after period match, enable stays set.
// - Family 10 codes 110/111: level start, opposite level clears; enable needed.
// - Count increments each clock; match flags postscaler, count clears next clock.
// - External reset events clear prescaler and postscaler counters.
module count_value_timer import count_value_pkg::*; #(
    parameter int NSRC = COUNT_VALUE_NSRC
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [NSRC-1:0] reset_sources,
    input wire logic debug_freeze,
    output logic period_match,
    output logic scaler_clear,
    output logic [7:0] count_value,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    // ==========================================================
    // Register state
    logic en_q;
    logic [4:0] limit_mode_control;
    logic [COUNT_VALUE_SRC_W-1:0] ext_reset_source_select;
    logic [7:0] period_value;
    logic [7:0] cnt_q;
    logic run_q;
    logic [7:0] aw_q;
    logic aw_have_q, w_have_q;
    logic [31:0] wd_q;
    logic [3:0] ws_q;
    logic wr_fire;
    logic en_wr, en_wr_val, hw_clr_en;

    // ==========================================================
    // External input selection and synchronisation
    logic sel_raw, sync1_q, sync2_q, prev_q;
    logic external_reset_signal;
    logic rise, fall, anyedge;
    assign sel_raw = reset_sources[ext_reset_source_select];

    // Two-flop synchroniser; the first stage feeds only the second
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
            prev_q <= 1'b0;
        end else begin
            sync1_q <= sel_raw;
            sync2_q <= sync1_q;
            prev_q <= sync2_q;
        end
    end

    // Freeze masks the input; no edge can leak out when freeze ends since prev tracks too
    assign external_reset_signal = sync2_q;
    assign rise = !debug_freeze && sync2_q && !prev_q;
    assign fall = !debug_freeze && !sync2_q && prev_q;
    assign anyedge = rise || fall;

    // ==========================================================
    // Mode decode: start, clear, gate and stop conditions
    logic [1:0] fam;
    logic [2:0] var3;
    logic lvl_hi, lvl_lo;
    logic start_ev, clr_ev, gate_ok, reserved, edge_mode, oneshot, mono;
    assign fam = limit_mode_control[4:3];
    assign var3 = limit_mode_control[2:0];
    assign lvl_hi = !debug_freeze && external_reset_signal;
    assign lvl_lo = !debug_freeze && !external_reset_signal;
    assign oneshot = (fam == COUNT_VALUE_FAM_ONESHOT) || (fam == COUNT_VALUE_FAM_MONO && var3[2:1] == 2'h3);
    assign mono = (fam == COUNT_VALUE_FAM_MONO) && (var3 inside {3'h1, 3'h2, 3'h3});
    assign reserved = (fam == 2'h3) || ((fam == COUNT_VALUE_FAM_MONO) && !mono && !oneshot);
    assign edge_mode = (fam != COUNT_VALUE_FAM_FREE) && !(fam == COUNT_VALUE_FAM_MONO && var3[2:1] == 2'h3)
        && (var3 != 3'h0);

    // Combinational decode per family
    always_comb begin
        start_ev = 1'b0;
        clr_ev = 1'b0;
        gate_ok = 1'b1;
        if (fam == COUNT_VALUE_FAM_FREE) begin
            unique case (var3)
                3'h0: ;
                3'h1: gate_ok = lvl_hi;
                3'h2: gate_ok = lvl_lo;
                3'h3: clr_ev = anyedge;
                3'h4: clr_ev = rise;
                3'h5: clr_ev = fall;
                3'h6: clr_ev = lvl_lo;
                3'h7: clr_ev = lvl_hi;
            endcase
        end else if (fam == COUNT_VALUE_FAM_ONESHOT || mono) begin
            unique case (var3)
                3'h0: start_ev = 1'b1;
                3'h1: start_ev = rise;
                3'h2: start_ev = fall;
                3'h3: start_ev = anyedge;
                3'h4: begin start_ev = rise; clr_ev = rise; end
                3'h5: begin start_ev = fall; clr_ev = fall; end
                3'h6: begin start_ev = rise; clr_ev = lvl_lo; end
                3'h7: begin start_ev = fall; clr_ev = lvl_hi; end
            endcase
        end else if (oneshot) begin
            start_ev = var3[0] ? lvl_lo : lvl_hi;
            clr_ev = var3[0] ? lvl_hi : lvl_lo;
        end
    end

    // ==========================================================
    // Counter core
    logic stopping, counting;
    assign period_match = (cnt_q == period_value) && counting;
    assign counting = en_q && !reserved && gate_ok && !clr_ev
        && ((fam == COUNT_VALUE_FAM_FREE) || run_q);
    assign stopping = period_match && (oneshot || mono);
    assign hw_clr_en = stopping && oneshot;
    assign scaler_clear = clr_ev || wr_fire;
    assign count_value = cnt_q;

    // Run flag: armed by a start event, dropped at period end or by disable
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            run_q <= 1'b0;
        end else if (!en_q || reserved) begin
            run_q <= 1'b0; // Edge must come after enable is back
        end else if (stopping) begin
            run_q <= 1'b0;
        end else if (start_ev) begin
            run_q <= 1'b1;
        end
    end

    // Count register: clear wins over increment; a software write to COUNT loads its value and wins over both
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_q <= 8'h00;
        end else if (wr_fire && aw_q == COUNT_VALUE_COUNT_OFS) begin
            cnt_q <= wd_q[7:0];
        end else if (clr_ev || period_match) begin
            cnt_q <= 8'h00;
        end else if (counting) begin
            cnt_q <= cnt_q + 8'h01;
        end
    end

    // Enable bit: hardware clear at one-shot end loses to a software set in that cycle
    assign en_wr = wr_fire && aw_q == COUNT_VALUE_CTRL_OFS && ws_q[0];
    assign en_wr_val = wd_q[COUNT_VALUE_CTRL_EN_BIT];
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            en_q <= 1'b0;
        end else if (en_wr) begin
            en_q <= en_wr_val;
        end else if (hw_clr_en) begin
            en_q <= 1'b0;
        end
    end

    // ==========================================================
    // AXI4-Lite slave: address and data taken in either order
    assign s_axi_awready = !aw_have_q && !s_axi_bvalid;
    assign s_axi_wready = !w_have_q && !s_axi_bvalid;
    assign wr_fire = aw_have_q && w_have_q && !s_axi_bvalid;

    // Write channel capture and response
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            aw_q <= 8'h00;
            wd_q <= 32'h0000_0000;
            ws_q <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= COUNT_VALUE_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_q <= 1'b1;
                aw_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_q <= 1'b1;
                wd_q <= s_axi_wdata;
                ws_q <= s_axi_wstrb;
            end
            if (wr_fire) begin
                aw_have_q <= 1'b0;
                w_have_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (aw_q > COUNT_VALUE_STAT_OFS || aw_q[1:0] != 2'h0)
                    ? COUNT_VALUE_RESP_SLVERR : COUNT_VALUE_RESP_OKAY;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Configuration registers; low byte lane only carries data
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            limit_mode_control <= COUNT_VALUE_MODE_RST;
            ext_reset_source_select <= COUNT_VALUE_SRC_RST;
            period_value <= COUNT_VALUE_PERIOD_RST;
        end else if (wr_fire && ws_q[0]) begin
            if (aw_q == COUNT_VALUE_MODE_OFS) limit_mode_control <= wd_q[4:0];
            if (aw_q == COUNT_VALUE_SRC_OFS) ext_reset_source_select <= wd_q[COUNT_VALUE_SRC_W-1:0];
            if (aw_q == COUNT_VALUE_PERIOD_OFS) period_value <= wd_q[7:0];
        end
    end

    // Read channel: one-cycle turnaround, data registered
    assign s_axi_arready = !s_axi_rvalid;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= COUNT_VALUE_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= COUNT_VALUE_RESP_OKAY;
            unique case (s_axi_araddr)
                COUNT_VALUE_CTRL_OFS: s_axi_rdata <= {31'h0, en_q};
                COUNT_VALUE_MODE_OFS: s_axi_rdata <= {27'h0, limit_mode_control};
                COUNT_VALUE_SRC_OFS: s_axi_rdata <= {29'h0, ext_reset_source_select};
                COUNT_VALUE_PERIOD_OFS: s_axi_rdata <= {24'h0, period_value};
                COUNT_VALUE_COUNT_OFS: s_axi_rdata <= {24'h0, cnt_q};
                COUNT_VALUE_STAT_OFS: s_axi_rdata <= {29'h0, reserved, sync2_q, run_q};
                default: begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= COUNT_VALUE_RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ==========================================================
    // Checks
    sequence match_seen_s;
        period_match && oneshot && !en_wr;
    endsequence
    oneshot_stop_a: assert property (@(posedge aclk) disable iff (!aresetn)
        match_seen_s |=> !en_q && cnt_q == 8'h00) else $error("one-shot did not stop");
    mono_keep_a: assert property (@(posedge aclk) disable iff (!aresetn)
        period_match && mono && !en_wr |=> en_q && cnt_q == 8'h00 && !run_q)
        else $error("monostable lost enable");
    wrap_zero_a: assert property (@(posedge aclk) disable iff (!aresetn)
        period_match && !wr_fire |=> cnt_q == 8'h00) else $error("no wrap after match");
    count_inc_a: assert property (@(posedge aclk) disable iff (!aresetn)
        counting && !period_match && !wr_fire |=> cnt_q == $past(cnt_q) + 8'h01)
        else $error("count did not step");
    freeze_mask_a: assert property (@(posedge aclk) disable iff (!aresetn)
        debug_freeze |-> !rise && !fall && !clr_ev && !scaler_clear || wr_fire)
        else $error("input seen in freeze");
    reserved_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
        reserved && !wr_fire ##1 reserved && !wr_fire |-> $stable(cnt_q))
        else $error("reserved mode counted");
    gate_high_a: assert property (@(posedge aclk) disable iff (!aresetn)
        fam == COUNT_VALUE_FAM_FREE && var3 == 3'h1 && !external_reset_signal && !wr_fire
        |=> $stable(cnt_q)) else $error("gate ignored");
    scaler_clr_a: assert property (@(posedge aclk) disable iff (!aresetn)
        clr_ev |-> scaler_clear) else $error("scalers not cleared");
    sync_edge_a: assert property (@(posedge aclk) disable iff (!aresetn)
        rise |-> $past(sync2_q) == 1'b0 && sync2_q) else $error("bad edge");
    restart_edge_a: assert property (@(posedge aclk) disable iff (!aresetn)
        $rose(en_q) && edge_mode |-> !run_q) else $error("restart without edge");
endmodule

// ===== test/count_value_src_model.sv
/*
 * Reset source model for the mode timer: the selected line follows the level
 * the bench asks for, with trigger spacing kept. Assumes the bench drives want.
 */
`timescale 1ns/1ns
module count_value_src_model (
    input wire logic aclk,
    input wire logic [2:0] sel,
    input wire logic want,
    output logic [7:0] srcs
);
    logic lvl_q = 1'b0;
    logic noise_q = 1'b0;
    logic [3:0] gap_q = 4'h0;
    // ==========================================================
    // Level changes
    // Changes are at least seven clocks apart, so every level also lasts over three
    always @(posedge aclk) begin
        noise_q <= ~noise_q;
        if (gap_q != 4'hF) gap_q <= gap_q + 4'h1;
        if (want != lvl_q && gap_q >= 4'h6) begin
            lvl_q <= want;
            gap_q <= 4'h0;
        end
    end
    // Unselected lines keep changing so a wrong select cannot look quiet
    always_comb for (int k = 0; k < 8; k++) srcs[k] = (k == sel) ? lvl_q : noise_q ^ k[0];
endmodule

// ===== test/count_value_timer_tb_top.sv
/*
 * Testbench for the mode timer: AXI4-Lite register tasks, corner and random scenarios.
 * Assumes the source model on reset_sources and a 4 ns clock.
 */
`timescale 1ns/1ns
module count_value_timer_tb_top import count_value_pkg::*;;
    logic aclk, aresetn, debug_freeze, want, pm_q, period_match, scaler_clear;
    logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    logic [2:0] sel;
    logic [7:0] srcs, count_value, awaddr, araddr, per;
    logic [31:0] wdata, rdata, d;
    logic [1:0] bresp, rresp, r;
    logic [3:0] wstrb;
    int n_errors, compares, seed, i, c;
    logic [7:0] ofs [6] = '{COUNT_VALUE_CTRL_OFS, COUNT_VALUE_MODE_OFS, COUNT_VALUE_SRC_OFS, COUNT_VALUE_PERIOD_OFS,
        COUNT_VALUE_COUNT_OFS, COUNT_VALUE_STAT_OFS};
    logic [31:0] rst_v [6] = '{32'h0, 32'h0, 32'h0, 32'hFF, 32'h0, 32'h0};
    // Start-controlled modes and the input level each one idles at before its trigger
    logic [4:0] md [10] = '{5'h08, 5'h09, 5'h0A, 5'h0B, 5'h0C, 5'h0D, 5'h0E, 5'h0F, 5'h16, 5'h17};
    logic pre [10] = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1};

    count_value_timer count_value_timer_i (.aclk(aclk), .aresetn(aresetn), .reset_sources(srcs),
        .debug_freeze(debug_freeze), .period_match(period_match), .scaler_clear(scaler_clear),
        .count_value(count_value), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
    count_value_src_model count_value_src_model_i (.aclk(aclk), .sel(sel), .want(want), .srcs(srcs));

    // ==========================================================
    // Clock, checks and bus tasks
    initial begin
        aclk = 1'b0;
        forever #2 aclk = ~aclk;
    end
    // Family 10 codes other than 110/111 keep enable after the period match; one-shot codes drop it
    function automatic logic keeps_en(input logic [4:0] m);
        return m[4:3] == COUNT_VALUE_FAM_MONO && m[2:0] != 3'h6 && m[2:0] != 3'h7;
    endfunction
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge aclk);
    endtask
    // Flags are read at the falling edge, where they equal what the next rising edge samples
    task automatic wr(input logic [7:0] a, input logic [31:0] dv);
        logic ta, tw, tr;
        ta = 1'b0;
        tw = 1'b0;
        tr = 1'b0;
        awaddr <= a;
        wdata <= dv;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        while (!(ta && tw)) begin
            @(negedge aclk);
            ta = ta | (awvalid & awready);
            tw = tw | (wvalid & wready);
            @(posedge aclk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
        end
        bready <= 1'b1;
        while (!tr) begin
            @(negedge aclk);
            tr = bvalid;
            r = bresp;
            @(posedge aclk);
        end
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        logic ta, tr;
        ta = 1'b0;
        tr = 1'b0;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!ta) begin
            @(negedge aclk);
            ta = arready;
            @(posedge aclk);
        end
        arvalid <= 1'b0;
        while (!tr) begin
            @(negedge aclk);
            tr = rvalid;
            d = rdata;
            r = rresp;
            @(posedge aclk);
        end
        // Read ready stays up between reads so back-to-back calls never toggle it in one step
    endtask
    // Polls until the one-shot drops its enable, then checks it parked at zero
    task automatic wait_off();
        for (int k = 0; k < 60; k++) begin
            rd(COUNT_VALUE_CTRL_OFS);
            if (d[0] === 1'b0) break;
        end
        chk("enable after one-shot", d, 32'h0);
        chk("count after one-shot", 32'(count_value), 32'h0);
    endtask
    task automatic conclude();
        $display("comparisons %0d, mismatches %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    // ==========================================================
    // Monitors
    // The clock after a match must show a cleared count
    always @(negedge aclk) begin
        if (aresetn === 1'b1 && pm_q === 1'b1) chk("count after match", 32'(count_value), 32'h0);
        pm_q = period_match;
    end
    // Whole run needs well under this span; a hang counts as a mismatch
    initial begin
        #160000;
        n_errors++;
        conclude();
    end

    // ==========================================================
    // Scenarios
    initial begin
        seed = 22;
        {aresetn, debug_freeze, want, awvalid, wvalid, bready, arvalid, rready} = '0;
        {sel, awaddr, araddr, wdata, n_errors, compares} = '0;
        wstrb = 4'hF;
        cyc(5);
        aresetn <= 1'b1;
        for (i = 0; i < 6; i++) begin
            rd(ofs[i]);
            chk("reset value", d, rst_v[i]);
            chk("read response", 32'(r), 32'(COUNT_VALUE_RESP_OKAY));
        end
        rd(8'h18);
        chk("unmapped data", d, 32'h0);
        chk("unmapped read", 32'(r), 32'(COUNT_VALUE_RESP_SLVERR));
        wr(8'h18, 32'h1);
        chk("unmapped write", 32'(r), 32'(COUNT_VALUE_RESP_SLVERR));
        c = $random(seed) & 7;
        sel <= c[2:0];
        wr(COUNT_VALUE_SRC_OFS, 32'(c));
        rd(COUNT_VALUE_SRC_OFS);
        chk("source select", d, 32'(c));
        wr(COUNT_VALUE_PERIOD_OFS, 32'h5);
        wr(COUNT_VALUE_CTRL_OFS, 32'h1);
        cyc(20);
        wr(COUNT_VALUE_CTRL_OFS, 32'h0);
        rd(COUNT_VALUE_COUNT_OFS);
        c = d;
        cyc(8);
        rd(COUNT_VALUE_COUNT_OFS);
        chk("count held when disabled", d, 32'(c));
        wr(COUNT_VALUE_COUNT_OFS, 32'h0);
        wr(COUNT_VALUE_MODE_OFS, 32'h1);
        wr(COUNT_VALUE_CTRL_OFS, 32'h1);
        cyc(20);
        rd(COUNT_VALUE_COUNT_OFS);
        chk("gate closed by low input", d, 32'h0);
        wr(COUNT_VALUE_MODE_OFS, 32'h7);
        want <= 1'b1;
        cyc(12);
        wr(COUNT_VALUE_COUNT_OFS, 32'h3);
        rd(COUNT_VALUE_COUNT_OFS);
        chk("held clear while high", d, 32'h0);
        rd(COUNT_VALUE_STAT_OFS);
        chk("synced input", 32'(d[1]), 32'h1);
        chk("scaler clear on external reset", 32'(scaler_clear), 32'h1);
        wr(COUNT_VALUE_CTRL_OFS, 32'h0);
        for (i = 0; i < 10; i++) begin
            want <= pre[i];
            cyc(12);
            wr(COUNT_VALUE_MODE_OFS, 32'(md[i]));
            wr(COUNT_VALUE_CTRL_OFS, 32'h1);
            if (i > 0) begin
                cyc(12);
                rd(COUNT_VALUE_COUNT_OFS);
                chk("no start without trigger", d, 32'h0);
                want <= !pre[i];
            end
            wait_off();
        end
        want <= 1'b0;
        cyc(12);
        wr(COUNT_VALUE_MODE_OFS, 32'h9);
        debug_freeze <= 1'b1;
        wr(COUNT_VALUE_CTRL_OFS, 32'h1);
        want <= 1'b1;
        cyc(20);
        chk("edge ignored in freeze", 32'(count_value), 32'h0);
        chk("no scaler clear in freeze", 32'(scaler_clear), 32'h0);
        wr(COUNT_VALUE_CTRL_OFS, 32'h0);
        debug_freeze <= 1'b0;
        want <= 1'b0;
        cyc(12);
        wr(COUNT_VALUE_MODE_OFS, 32'h11);
        wr(COUNT_VALUE_CTRL_OFS, 32'h1);
        want <= 1'b1;
        cyc(30);
        rd(COUNT_VALUE_CTRL_OFS);
        chk("monostable enable", d, 32'(keeps_en(5'h11)));
        chk("monostable count", 32'(count_value), 32'h0);
        wr(COUNT_VALUE_MODE_OFS, 32'h18);
        cyc(20);
        chk("reserved mode stopped", 32'(count_value), 32'h0);
        rd(COUNT_VALUE_STAT_OFS);
        chk("reserved mode flag", 32'(d[2]), 32'h1);
        // Free-running edge resets: without the clear the count would be far past 16
        for (i = 3; i < 6; i++) begin
            want <= (i == 5);
            cyc(12);
            wr(COUNT_VALUE_MODE_OFS, 32'(i));
            wr(COUNT_VALUE_PERIOD_OFS, 32'hFF);
            wr(COUNT_VALUE_CTRL_OFS, 32'h1);
            cyc(40);
            want <= (i != 5);
            cyc(12);
            chk("edge clears count", 32'(count_value < 8'h10), 32'h1);
            wr(COUNT_VALUE_CTRL_OFS, 32'h0);
        end
        wr(COUNT_VALUE_CTRL_OFS, 32'h0);
        wr(COUNT_VALUE_MODE_OFS, 32'h0);
        for (i = 0; i < 16; i++) begin
            per = (i == 0) ? 8'h01 : (i == 1) ? 8'hFF : 8'($random(seed)) | 8'h01;
            wr(COUNT_VALUE_PERIOD_OFS, 32'(per));
            wr(COUNT_VALUE_COUNT_OFS, 32'h0);
            wr(COUNT_VALUE_CTRL_OFS, 32'h1);
            cyc($unsigned($random(seed)) % 40);
            wr(COUNT_VALUE_CTRL_OFS, 32'h0);
            chk("count within period", 32'(count_value <= per), 32'h1);
        end
        conclude();
    end
endmodule
